// >>> core/flash_error_protection.sv
// Flash error status, option protection and program staging registers.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Faults set matching error status bit.
// - Writing bit0 zero clears keys, control.
// - Invalid command sets configuration error bit.
// - Smart option word readable via readback.
// - Protection option word readable via readback.
// - Protection bit 8 low enables load protection.
// - Protection bit 17 low enables hardware lock.
// - Protection bit 27 low enables read protection.
// - Smart option word sizes protected areas.
// - Tool mode reads return zero when protected.
// - Lock refuses locked writes and option changes.
// - Lock holds in tool mode; chip erase releases.
// - Read protection changes need lock disabled.
// - Option erase restores all option bits.
// - Tool chip erase restores options, erases array.
// - Keys clear when an operation completes.
// - More than one enable bit is error.
module flash_error_protection (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // APB slave.
   input wire flash_prot_pkg::apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash array operation port.
   output flash_prot_pkg::flash_op_t flashOp,
   input wire logic opDone,
   input wire logic opFault,
   // Tool program mode side.
   input wire logic toolModePin,
   input wire logic toolChipErase,
   input wire logic toolOptWrite,
   input wire logic [31:0] toolAddr,
   input wire logic [31:0] toolData,
   input wire logic [31:0] toolArrayData,
   output logic [31:0] toolReadData,
   output logic toolWriteDenied,
   // Load instruction check.
   input wire logic [31:0] ldAddr,
   output logic ldDenied
);
   typedef struct packed {
      logic [3:0][7:0] key;
      logic [31:0] progAddr;
      logic [31:0] progData;
      logic [7:0] ctrl;
      logic configuration_error_flag;
      logic faultErr;
      logic denyErr;
      logic clearPend;
      flash_prot_pkg::state_t st;
      logic [31:0] rdata;
      logic slvErr;
      logic [31:0] toolRead;
      logic toolDeny;
      logic ldDeny;
      flash_prot_pkg::flash_op_t op;
      logic optWe;
      logic optSel;
      logic [31:0] optData;
      logic optErase;
      logic toolMeta;
      logic toolSync;
   } core_t;

   core_t s;
   core_t next_s;
   logic [31:0] smartWord;
   logic [31:0] protWord;
   logic lockOn;
   logic ldOn;
   logic readProtOn;

   option_store #(
      .FACTORY(flash_prot_pkg::OPT_ERASED)
   ) store (
      .clock(clock),
      .we(s.optWe),
      .selProt(s.optSel),
      .wdata(s.optData),
      .eraseAll(s.optErase),
      .smartWord(smartWord),
      .protWord(protWord)
   );

   // Option bits are active low.
   assign lockOn = !protWord[flash_prot_pkg::PROT_LOCK];
   assign ldOn = !protWord[flash_prot_pkg::PROT_LD];
   assign readProtOn = !protWord[flash_prot_pkg::PROT_READ];

   // Size of the area a protection covers, from two smart bits.
   function automatic logic inArea(input logic [31:0] a,
         input logic sel8k, input logic sel16k);
      if (!sel8k)
         return a < flash_prot_pkg::AREA_8K;
      else if (!sel16k)
         return a < flash_prot_pkg::AREA_16K;
      else
         return 1'b1;
   endfunction

   function automatic logic isOptAddr(input logic [31:0] a);
      return a == flash_prot_pkg::OPT_SMART_ADDR ||
         a == flash_prot_pkg::OPT_PROT_ADDR;
   endfunction

   logic lockedProg;
   logic lockedTool;
   logic lockedLd;
   assign lockedProg = lockOn && inArea(s.progAddr,
      smartWord[flash_prot_pkg::SMART_LOCK8K],
      smartWord[flash_prot_pkg::SMART_LOCK16K]);
   assign lockedTool = lockOn && (isOptAddr(toolAddr) ||
      inArea(toolAddr, smartWord[flash_prot_pkg::SMART_LOCK8K],
      smartWord[flash_prot_pkg::SMART_LOCK16K]));
   assign lockedLd = ldOn && inArea(ldAddr,
      smartWord[flash_prot_pkg::SMART_LD8K],
      smartWord[flash_prot_pkg::SMART_LD16K]);

   // Bus decode.
   logic setup;
   logic wrAccess;
   logic [13:0] idx;
   logic aligned;
   logic hit;
   logic [31:0] readMux;
   assign setup = apbReq.psel && !apbReq.penable;
   assign wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign idx = apbReq.paddr[15:2];
   assign aligned = apbReq.paddr[1:0] == 2'h0;

   always_comb
   begin
      hit = aligned;
      readMux = 32'h00000000;
      if (idx >= flash_prot_pkg::IDX_KEY0 && idx <= flash_prot_pkg::IDX_KEY3)
         readMux = 32'h00000000;
      else
      begin
         unique case (idx)
            flash_prot_pkg::IDX_ADDR: readMux = s.progAddr;
            flash_prot_pkg::IDX_DATA: readMux = s.progData;
            flash_prot_pkg::IDX_CTRL: readMux = {24'h000000, s.ctrl};
            flash_prot_pkg::IDX_ERR:
               readMux = {24'h000000, s.configuration_error_flag, s.faultErr, s.denyErr,
                  4'h0, !s.clearPend};
            flash_prot_pkg::IDX_SMART: readMux = smartWord;
            flash_prot_pkg::IDX_PROT: readMux = protWord;
            default: hit = 1'b0;
         endcase
      end
   end

   // Command checks on a pending start.
   logic [2:0] enCount;
   logic keysOk;
   always_comb
   begin
      enCount = 3'h0;
      for (int i = 0; i < 4; i++)
         enCount = enCount + {2'h0, s.ctrl[i]};
   end
   assign keysOk = s.key[0] == flash_prot_pkg::KEY_A &&
      s.key[1] == flash_prot_pkg::KEY_B &&
      s.key[2] == flash_prot_pkg::KEY_A &&
      s.key[3] == flash_prot_pkg::KEY_B;

   logic setCfg;
   logic setFault;
   logic setDeny;
   logic finish;
   logic [1:0] keyIdx;
   assign keyIdx = apbReq.paddr[3:2];

   always_comb
   begin
      next_s = s;
      setCfg = 1'b0;
      setFault = 1'b0;
      setDeny = 1'b0;
      finish = 1'b0;
      next_s.op.start = 1'b0;
      next_s.optWe = 1'b0;
      next_s.optErase = 1'b0;
      next_s.toolMeta = toolModePin;
      next_s.toolSync = s.toolMeta;

      // Read data and error answer are prepared in the setup cycle.
      if (setup)
      begin
         next_s.rdata = hit ? readMux : 32'h00000000;
         next_s.slvErr = !hit;
      end

      // A clear request lasts one cycle, so bit 0 reads 0 once.
      if (s.clearPend)
      begin
         next_s.key = '0;
         next_s.ctrl = flash_prot_pkg::CTRL_RESET;
         next_s.clearPend = 1'b0;
      end

      if (wrAccess && hit)
      begin
         if (idx >= flash_prot_pkg::IDX_KEY0 &&
               idx <= flash_prot_pkg::IDX_KEY3)
            next_s.key[keyIdx] = apbReq.pwdata[7:0];
         else
         begin
            unique case (idx)
               flash_prot_pkg::IDX_ADDR: next_s.progAddr = apbReq.pwdata;
               flash_prot_pkg::IDX_DATA: next_s.progData = apbReq.pwdata;
               flash_prot_pkg::IDX_CTRL:
               begin
                  // A running or pending command cannot be rewritten.
                  if (s.st == flash_prot_pkg::ST_IDLE &&
                        !s.ctrl[flash_prot_pkg::CTRL_START])
                     next_s.ctrl = {apbReq.pwdata[7], 3'h0,
                        apbReq.pwdata[3:0]};
               end
               flash_prot_pkg::IDX_ERR:
               begin
                  if (!apbReq.pwdata[flash_prot_pkg::ERR_CLR])
                     next_s.clearPend = 1'b1;
                  // Error bits written 0 are cleared.
                  if (!apbReq.pwdata[flash_prot_pkg::ERR_CFG])
                     next_s.configuration_error_flag = 1'b0;
                  if (!apbReq.pwdata[flash_prot_pkg::ERR_FAULT])
                     next_s.faultErr = 1'b0;
                  if (!apbReq.pwdata[flash_prot_pkg::ERR_DENY])
                     next_s.denyErr = 1'b0;
               end
               default: ;
            endcase
         end
      end

      unique case (s.st)
         flash_prot_pkg::ST_IDLE:
         begin
            if (s.toolSync && toolChipErase)
            begin
               // Only a tool chip erase releases the lock.
               next_s.optErase = 1'b1;
               next_s.op.start = 1'b1;
               next_s.op.kind = flash_prot_pkg::OP_CHIP;
               next_s.st = flash_prot_pkg::ST_BUSY;
            end
            else if (s.toolSync && toolOptWrite && isOptAddr(toolAddr))
            begin
               if (lockOn)
                  setDeny = 1'b1;
               else
               begin
                  next_s.optWe = 1'b1;
                  next_s.optSel = toolAddr == flash_prot_pkg::OPT_PROT_ADDR;
                  next_s.optData = toolData;
               end
            end
            else if (s.ctrl[flash_prot_pkg::CTRL_START] && !s.clearPend)
            begin
               finish = 1'b1;
               if (enCount != 3'h1)
                  setCfg = 1'b1;
               else if (!keysOk)
                  setDeny = 1'b1;
               else if (s.ctrl[flash_prot_pkg::CTRL_OPT_PROG])
               begin
                  // Covers lock and read protection changes alike.
                  if (lockOn || !isOptAddr(s.progAddr))
                     setDeny = 1'b1;
                  else
                  begin
                     next_s.optWe = 1'b1;
                     next_s.optSel =
                        s.progAddr == flash_prot_pkg::OPT_PROT_ADDR;
                     next_s.optData = s.progData;
                  end
               end
               else if (s.ctrl[flash_prot_pkg::CTRL_OPT_ERASE])
               begin
                  if (lockOn)
                     setDeny = 1'b1;
                  else
                     next_s.optErase = 1'b1;
               end
               else if (lockedProg)
                  setDeny = 1'b1;
               else
               begin
                  finish = 1'b0;
                  next_s.op.start = 1'b1;
                  next_s.op.addr = s.progAddr;
                  next_s.op.data = s.progData;
                  next_s.op.kind = s.ctrl[flash_prot_pkg::CTRL_NORM_PROG] ?
                     flash_prot_pkg::OP_PROG : flash_prot_pkg::OP_ERASE;
                  next_s.st = flash_prot_pkg::ST_BUSY;
               end
            end
         end
         flash_prot_pkg::ST_BUSY:
         begin
            if (opDone)
            begin
               setFault = opFault;
               finish = 1'b1;
               next_s.st = flash_prot_pkg::ST_IDLE;
            end
         end
      endcase

      if (finish)
      begin
         next_s.key = '0;
         next_s.ctrl[flash_prot_pkg::CTRL_START] = 1'b0;
      end

      // Hardware setting wins over a software clear in the same cycle.
      if (setCfg)
         next_s.configuration_error_flag = 1'b1;
      if (setFault)
         next_s.faultErr = 1'b1;
      if (setDeny)
         next_s.denyErr = 1'b1;

      next_s.toolRead = (s.toolSync && readProtOn) ?
         32'h00000000 : toolArrayData;
      next_s.toolDeny = lockedTool;
      next_s.ldDeny = lockedLd;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s.key <= '0;
         s.progAddr <= flash_prot_pkg::WORD_RESET;
         s.progData <= flash_prot_pkg::WORD_RESET;
         s.ctrl <= flash_prot_pkg::CTRL_RESET;
         s.configuration_error_flag <= flash_prot_pkg::ERR_RESET[flash_prot_pkg::ERR_CFG];
         s.faultErr <= 1'b0;
         s.denyErr <= 1'b0;
         s.clearPend <= 1'b0;
         s.st <= flash_prot_pkg::ST_IDLE;
         s.rdata <= 32'h00000000;
         s.slvErr <= 1'b0;
         s.toolRead <= 32'h00000000;
         s.toolDeny <= 1'b0;
         s.ldDeny <= 1'b0;
         s.op <= '0;
         s.optWe <= 1'b0;
         s.optSel <= 1'b0;
         s.optData <= flash_prot_pkg::OPT_ERASED;
         s.optErase <= 1'b0;
         s.toolMeta <= 1'b0;
         s.toolSync <= 1'b0;
      end
      else
         s <= next_s;
   end

   // The slave never waits: every access phase completes at once.
   assign pready = apbReq.psel && apbReq.penable;
   assign pslverr = pready && s.slvErr;
   assign prdata = s.rdata;
   assign flashOp = s.op;
   assign toolReadData = s.toolRead;
   assign toolWriteDenied = s.toolDeny;
   assign ldDenied = s.ldDeny;
endmodule // flash_error_protection
`default_nettype wire

// >>> core/flash_prot_pkg.sv
// Shared constants and types of the flash error and protection block.
`default_nettype none
package flash_prot_pkg;
   // Register indices; the byte address is four times the index.
   localparam logic [13:0] IDX_KEY0 = 14'h3010;
   localparam logic [13:0] IDX_KEY3 = 14'h3013;
   localparam logic [13:0] IDX_ADDR = 14'h3014;
   localparam logic [13:0] IDX_DATA = 14'h3018;
   localparam logic [13:0] IDX_CTRL = 14'h301f;
   localparam logic [13:0] IDX_ERR = 14'h3023;
   localparam logic [13:0] IDX_SMART = 14'h3028;
   localparam logic [13:0] IDX_PROT = 14'h302c;
   // Error status fields.
   localparam logic [7:0] ERR_RESET = 8'h01;
   localparam int ERR_CLR = 0;
   localparam int ERR_DENY = 5;
   localparam int ERR_FAULT = 6;
   localparam int ERR_CFG = 7;
   // Program control fields.
   localparam int CTRL_OPT_ERASE = 0;
   localparam int CTRL_NORM_ERASE = 1;
   localparam int CTRL_OPT_PROG = 2;
   localparam int CTRL_NORM_PROG = 3;
   localparam int CTRL_START = 7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h00000000;
   // Unlock key sequence.
   localparam logic [7:0] KEY_A = 8'h5a;
   localparam logic [7:0] KEY_B = 8'ha5;
   // Option word addresses and fields.
   localparam logic [31:0] OPT_SMART_ADDR = 32'h00000e38;
   localparam logic [31:0] OPT_PROT_ADDR = 32'h00000e3c;
   localparam int PROT_LD = 8;
   localparam int PROT_LOCK = 17;
   localparam int PROT_READ = 27;
   localparam int SMART_LOCK8K = 0;
   localparam int SMART_LOCK16K = 8;
   localparam int SMART_LD8K = 16;
   localparam int SMART_LD16K = 24;
   localparam logic [31:0] AREA_8K = 32'h00002000;
   localparam logic [31:0] AREA_16K = 32'h00004000;
   localparam logic [31:0] OPT_ERASED = 32'hffffffff;

   typedef enum logic [1:0] {
      OP_PROG = 2'h0,
      OP_ERASE = 2'h1,
      OP_CHIP = 2'h2
   } op_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [15:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic start;
      op_kind_t kind;
      logic [31:0] addr;
      logic [31:0] data;
   } flash_op_t;
endpackage
`default_nettype wire

// >>> core/option_store.sv
// Nonvolatile smart and protection option words with registered readback.
`timescale 1ns/100ps
`default_nettype none
module option_store #(
   parameter logic [31:0] FACTORY = flash_prot_pkg::OPT_ERASED
) (
   // Clock.
   input wire logic clock,
   // Update port.
   input wire logic we,
   input wire logic selProt,
   input wire logic [31:0] wdata,
   input wire logic eraseAll,
   // Readback.
   output logic [31:0] smartWord,
   output logic [31:0] protWord
);
   typedef struct packed {
      logic [31:0] smart;
      logic [31:0] prot;
   } store_t;

   // The cells keep their content across reset, as the flash cells do.
   store_t s = {FACTORY, FACTORY};
   store_t next_s;

   always_comb
   begin
      next_s = s;
      if (eraseAll)
      begin
         next_s.smart = flash_prot_pkg::OPT_ERASED;
         next_s.prot = flash_prot_pkg::OPT_ERASED;
      end
      else if (we)
      begin
         // A cell only moves from 1 to 0 when programmed.
         if (selProt)
            next_s.prot = s.prot & wdata;
         else
            next_s.smart = s.smart & wdata;
      end
   end

   always_ff @(posedge clock)
      s <= next_s;

   assign smartWord = s.smart;
   assign protWord = s.prot;
endmodule // option_store
`default_nettype wire

// >>> verification/flash_prot_props.sv
// Port checks of the flash error and protection block.
`timescale 1ns/100ps
`default_nettype none
module flash_prot_props (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst,
   // Watched ports.
   input wire flash_prot_pkg::apb_req_t apbReq,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire flash_prot_pkg::flash_op_t flashOp,
   input wire logic toolModePin,
   input wire logic toolChipErase,
   input wire logic [31:0] toolArrayData,
   input wire logic [31:0] toolReadData,
   input wire logic toolWriteDenied,
   input wire logic ldDenied
);
   logic chipGo;
   assign chipGo = flashOp.start && flashOp.kind == flash_prot_pkg::OP_CHIP;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // The mode pin passes a synchroniser, so it must stand before it counts.
   sequence toolSettled;
      toolModePin [*4] ##0 toolChipErase;
   endsequence
   sequence opIssued;
      flashOp.start ##1 !flashOp.start;
   endsequence
   AST_PREADY: assert property (pready == (apbReq.psel && apbReq.penable))
      else $error("pready not tied to access phase");
   AST_SLVERR: assert property (pslverr |-> pready)
      else $error("pslverr outside access phase");
   AST_PRDATA_HOLD: assert property (pready |=> $stable(prdata))
      else $error("prdata moved in access phase");
   AST_RESET_OUT: assert property ($fell(rst) |-> flashOp == '0 && !ldDenied
      && !toolWriteDenied && toolReadData == 32'h0)
      else $error("outputs not cleared by reset");
   AST_START_PULSE: assert property (flashOp.start |-> opIssued)
      else $error("start not a single pulse");
   AST_OP_HOLD: assert property (flashOp.start |=>
      ($stable(flashOp.kind) && $stable(flashOp.addr)) [*2])
      else $error("operation fields moved");
   AST_TOOL_READ: assert property (toolReadData != 32'h0 |->
      toolReadData == $past(toolArrayData))
      else $error("tool read data not the array data");
   AST_CHIP_ERASE: assert property (
      toolSettled |-> ##[1:4] chipGo)
      else $error("chip erase not issued");
endmodule // flash_prot_props
bind flash_error_protection flash_prot_props props (
   .clock(clock),
   .rst(rst),
   .apbReq(apbReq),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .flashOp(flashOp),
   .toolModePin(toolModePin),
   .toolChipErase(toolChipErase),
   .toolArrayData(toolArrayData),
   .toolReadData(toolReadData),
   .toolWriteDenied(toolWriteDenied),
   .ldDenied(ldDenied)
);
`default_nettype wire

// >>> verification/flash_error_protection_tb.sv
// Self-checking testbench of the flash error and protection block.
`timescale 1ns/100ps
`default_nettype none
module flash_error_protection_tb;
   logic clock = 1'b0;
   logic rst = 1'b1;
   flash_prot_pkg::apb_req_t apbReq = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   flash_prot_pkg::flash_op_t flashOp;
   flash_prot_pkg::flash_op_t seenOp = '0;
   logic opDone = 1'b0;
   logic opFault = 1'b0;
   logic faultNext = 1'b0;
   logic toolModePin = 1'b0;
   logic toolChipErase = 1'b0;
   logic toolOptWrite = 1'b0;
   logic [31:0] toolAddr = 32'h0;
   logic [31:0] toolData = 32'h0;
   logic [31:0] toolArrayData = 32'h0;
   logic [31:0] toolReadData;
   logic toolWriteDenied;
   logic [31:0] ldAddr = 32'h0;
   logic ldDenied;
   logic [31:0] rd;
   logic expErr = 1'b0;
   int errCount = 0;
   int samplesChecked = 0;
   int cycles = 0;

   flash_error_protection dut (
      .clock(clock),
      .rst(rst),
      .apbReq(apbReq),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .flashOp(flashOp),
      .opDone(opDone),
      .opFault(opFault),
      .toolModePin(toolModePin),
      .toolChipErase(toolChipErase),
      .toolOptWrite(toolOptWrite),
      .toolAddr(toolAddr),
      .toolData(toolData),
      .toolArrayData(toolArrayData),
      .toolReadData(toolReadData),
      .toolWriteDenied(toolWriteDenied),
      .ldAddr(ldAddr),
      .ldDenied(ldDenied)
   );

   initial
   begin
      forever #50 clock = ~clock;
   end

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samplesChecked, errCount);
      if (errCount == 0 && samplesChecked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // The array answers every started operation one cycle later.
   always @(posedge clock)
   begin
      opDone <= flashOp.start;
      opFault <= faultNext;
      if (flashOp.start)
         seenOp <= flashOp;
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         errCount++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, got);
      samplesChecked++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", nm, exp, got);
         errCount++;
      end
   endtask

   // The master waits on pready, so any slave latency is accepted.
   task automatic apb(input logic wr, input logic [13:0] idx,
      input logic [31:0] wd);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr,
         paddr: {idx, 2'b00}, pwdata: wd};
      @(posedge clock);
      apbReq.penable <= 1'b1;
      // Only the bench timeout ends a wait that never sees pready.
      do
      begin
         @(posedge clock);
      end
      while (pready !== 1'b1);
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      chk("pslverr", {31'h0, expErr}, {31'h0, pslverr});
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic rchk(input string nm, input logic [13:0] idx,
      input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(nm, exp, rd);
   endtask

   task automatic cmd(input logic [31:0] a, d, input logic [7:0] ctl);
      apb(1'b1, flash_prot_pkg::IDX_ADDR, a);
      apb(1'b1, flash_prot_pkg::IDX_DATA, d);
      apb(1'b1, flash_prot_pkg::IDX_KEY0, 32'h5a);
      apb(1'b1, flash_prot_pkg::IDX_KEY0 + 14'h1, 32'ha5);
      apb(1'b1, flash_prot_pkg::IDX_KEY0 + 14'h2, 32'h5a);
      apb(1'b1, flash_prot_pkg::IDX_KEY3, 32'ha5);
      apb(1'b1, flash_prot_pkg::IDX_CTRL, {24'h0, ctl});
      apb(1'b1, flash_prot_pkg::IDX_CTRL, {24'h0, ctl | 8'h80});
      repeat (6) @(posedge clock);
   endtask

   task automatic clear_err();
      apb(1'b1, flash_prot_pkg::IDX_ERR, 32'h0);
      repeat (2) @(posedge clock);
   endtask

   task automatic tool_pulse(input logic chip);
      if (chip)
         toolChipErase <= 1'b1;
      else
         toolOptWrite <= 1'b1;
      @(posedge clock);
      toolChipErase <= 1'b0;
      toolOptWrite <= 1'b0;
      repeat (6) @(posedge clock);
   endtask

   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rchk("err", flash_prot_pkg::IDX_ERR, 32'h01);
      rchk("smart", flash_prot_pkg::IDX_SMART, 32'hffffffff);
      expErr = 1'b1;
      rchk("unmapped", 14'h3000, 32'h0);
      expErr = 1'b0;
      apb(1'b1, flash_prot_pkg::IDX_PROT, 32'h0);
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hffffffff);
      cmd(32'h8000, 32'h0, 8'h05);
      rchk("err", flash_prot_pkg::IDX_ERR, 32'h81);
      clear_err();
      rchk("err", flash_prot_pkg::IDX_ERR, 32'h01);
      rchk("ctrl", flash_prot_pkg::IDX_CTRL, 32'h0);
      cmd(32'he3c, 32'hfffffeff, 8'h04);
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hfffffeff);
      apb(1'b1, flash_prot_pkg::IDX_CTRL, 32'h84);
      repeat (6) @(posedge clock);
      rchk("err", flash_prot_pkg::IDX_ERR, 32'h21);
      clear_err();
      ldAddr <= 32'h3000;
      repeat (3) @(posedge clock);
      chk("ld", 32'h1, {31'h0, ldDenied});
      cmd(32'he38, 32'hfffeffff, 8'h04);
      rchk("smart", flash_prot_pkg::IDX_SMART, 32'hfffeffff);
      chk("ld", 32'h0, {31'h0, ldDenied});
      cmd(32'he3c, 32'hf7ffffff, 8'h04);
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hf7fffeff);
      toolArrayData <= 32'h12345678;
      toolModePin <= 1'b1;
      repeat (5) @(posedge clock);
      chk("toolrd", 32'h0, toolReadData);
      toolModePin <= 1'b0;
      repeat (5) @(posedge clock);
      chk("toolrd", 32'h12345678, toolReadData);
      cmd(32'he3c, 32'h0, 8'h01);
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hffffffff);
      rchk("smart", flash_prot_pkg::IDX_SMART, 32'hffffffff);
      cmd(32'he3c, 32'hff00ffff, 8'h04);
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hff00ffff);
      toolAddr <= 32'h100;
      repeat (3) @(posedge clock);
      chk("deny", 32'h1, {31'h0, toolWriteDenied});
      cmd(32'he3c, 32'hf7ffffff, 8'h04);
      rchk("err", flash_prot_pkg::IDX_ERR, 32'h21);
      clear_err();
      cmd(32'he3c, 32'h0, 8'h01);
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hff00ffff);
      clear_err();
      toolAddr <= 32'he3c;
      toolData <= 32'hf7ffffff;
      toolModePin <= 1'b1;
      repeat (5) @(posedge clock);
      chk("deny", 32'h1, {31'h0, toolWriteDenied});
      tool_pulse(1'b0);
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hff00ffff);
      tool_pulse(1'b1);
      chk("kind", {30'h0, flash_prot_pkg::OP_CHIP},
         {30'h0, seenOp.kind});
      rchk("prot", flash_prot_pkg::IDX_PROT, 32'hffffffff);
      chk("deny", 32'h0, {31'h0, toolWriteDenied});
      toolModePin <= 1'b0;
      clear_err();
      faultNext <= 1'b1;
      cmd(32'h8000, 32'hcafe0001, 8'h08);
      chk("opaddr", 32'h8000, seenOp.addr);
      chk("opdata", 32'hcafe0001, seenOp.data);
      rchk("err", flash_prot_pkg::IDX_ERR, 32'h41);
      clear_err();
      rchk("err", flash_prot_pkg::IDX_ERR, 32'h01);
      tally_and_finish();
   end
endmodule // flash_error_protection_tb
`default_nettype wire
